// [common/swc_pkg.sv]
// Package for the sleep and wake-up controller: register map, field positions, states.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers.
package swc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_INTCTL = 8'h00;
    localparam logic [7:0] OFF_CHGEN = 8'h04;
    localparam logic [7:0] OFF_PFLAGS = 8'h08;
    localparam logic [7:0] OFF_PEN = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    // Reset values
    localparam logic [7:0] RST_INTCTL = 8'h00;
    localparam logic [7:0] RST_CHGEN = 8'h00;
    localparam logic [7:0] RST_PFLAGS = 8'h00;
    localparam logic [7:0] RST_PEN = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // Control register fields
    localparam int GIE_BIT = 7;
    localparam int PEIE_BIT = 6;
    localparam int INTE_BIT = 4;
    localparam int CHGE_BIT = 3;
    localparam int EXT_IRQ_FLAG_BIT = 1;
    localparam int CHGF_BIT = 0;
    localparam int WDTEN_BIT = 0;
    // Peripheral flags: unimplemented bit, and bits that still flag with the clock stopped
    localparam logic [7:0] PFLAG_MASK = 8'hEF;
    localparam logic [7:0] PFLAG_SLEEPOK = 8'hE9;
    // Status register fields
    localparam int PD_BIT = 0;
    localparam int TO_BIT = 1;
    localparam int SLEEP_BIT = 2;
    // Fixed interrupt vector
    localparam logic [7:0] IRQ_VECTOR = 8'h04;
    // Latency in instruction cycles
    localparam int LAT_SYNC = 3;
    typedef enum logic [1:0] {SWC_RUN, SWC_SLEEP, SWC_WAKE} swc_state_t;
endpackage

// [src/swc_sleep_wakeup_control.sv]
// Sleep entry and wake-up control, registers reached over Avalon-MM.
// Assumes sources are synchronous to clk except the interrupt pin and reset pin.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module swc_sleep_wakeup_control #(
    parameter int LATENCY = swc_pkg::LAT_SYNC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic [1:0] avsResponse,
    input wire logic sleepInstr,
    input wire logic watchdogClearInstr,
    input wire logic watchdogTimeout,
    input wire logic externalResetPin,
    input wire logic extIrqPin,
    input wire logic phaseQ4Q1,
    input wire logic [5:0] pinChange,
    input wire logic [7:0] periphEvent,
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOutEnableN,
    output logic [5:0] heldPinOut,
    output logic [5:0] heldPinOutEnableN,
    output logic oscDriverEnable,
    output logic watchdogClear,
    output logic coreReset,
    output logic externalResetDriveN,
    output logic prefetchNext,
    output logic wakeVector,
    output logic [7:0] vectorAddress,
    output logic sleeping
);
    typedef struct packed {
        swc_pkg::swc_state_t state;
        logic [7:0] intCtl;
        logic [7:0] chgEn;
        logic [7:0] pFlags;
        logic [7:0] pEn;
        logic wdtEn;
        logic powerdownFlagN;
        logic timeoutFlagN;
        logic [5:0] pinHold;
        logic [5:0] oeHold;
        logic wdClr;
        logic coreRst;
        logic vecPend;
        logic [2:0] latCnt;
        logic vec;
        logic pref;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [1:0] irqSync;
        logic [1:0] mclrSync;
        logic irqPrev;
    } swc_regs_t;

    swc_regs_t cur;
    swc_regs_t next_cur;
    logic wakeRequest;
    logic intPending;
    logic busReq;
    logic irqEdge;
    logic mclrLow;

    always_comb begin
        intPending = (cur.intCtl[swc_pkg::INTE_BIT] & cur.intCtl[swc_pkg::EXT_IRQ_FLAG_BIT])
            | (cur.intCtl[swc_pkg::CHGE_BIT] & cur.intCtl[swc_pkg::CHGF_BIT])
            | (cur.intCtl[swc_pkg::PEIE_BIT] & |(cur.pFlags & cur.pEn));
        wakeRequest = intPending;
    end

    // Pin sync stages; only the second stage is read
    assign irqEdge = cur.irqSync[1] & ~cur.irqPrev;
    assign mclrLow = ~cur.mclrSync[1];
    // Ack blocks a second capture while the master still holds the request
    assign busReq = (avsRead | avsWrite) & ~cur.ack;

    // Next-state logic for the whole block
    always_comb begin
        next_cur = cur;
        // Two-flop synchronisers for the asynchronous pins
        next_cur.irqSync = {cur.irqSync[0], extIrqPin};
        next_cur.mclrSync = {cur.mclrSync[0], externalResetPin};
        next_cur.irqPrev = cur.irqSync[1];
        // Pulse outputs default low every cycle
        next_cur.wdClr = 1'b0;
        next_cur.coreRst = 1'b0;
        next_cur.vec = 1'b0;
        next_cur.pref = 1'b0;
        next_cur.ack = 1'b0;
        // Bus access; one wait cycle, answered next edge
        // Writes land at the capture edge, one edge before completion
        if (busReq) begin
            next_cur.ack = 1'b1;
            next_cur.resp = 2'h0;
            next_cur.rdata = 32'h0000_0000;
            if (avsAddress == swc_pkg::OFF_INTCTL) begin
                next_cur.rdata = {24'h00_0000, cur.intCtl};
                if (avsWrite && avsByteEnable[0]) begin
                    next_cur.intCtl = avsWriteData[7:0];
                end
            end else if (avsAddress == swc_pkg::OFF_CHGEN) begin
                next_cur.rdata = {24'h00_0000, cur.chgEn};
                if (avsWrite && avsByteEnable[0]) begin
                    next_cur.chgEn = avsWriteData[7:0] & 8'h3F;
                end
            end else if (avsAddress == swc_pkg::OFF_PFLAGS) begin
                next_cur.rdata = {24'h00_0000, cur.pFlags};
                if (avsWrite && avsByteEnable[0]) begin
                    next_cur.pFlags = avsWriteData[7:0] & swc_pkg::PFLAG_MASK;
                end
            end else if (avsAddress == swc_pkg::OFF_PEN) begin
                next_cur.rdata = {24'h00_0000, cur.pEn};
                if (avsWrite && avsByteEnable[0]) begin
                    next_cur.pEn = avsWriteData[7:0] & swc_pkg::PFLAG_MASK;
                end
            end else if (avsAddress == swc_pkg::OFF_STATUS) begin
                next_cur.rdata = {29'h0000_0000, cur.state == swc_pkg::SWC_SLEEP,
                    cur.timeoutFlagN, cur.powerdownFlagN};
            end else if (avsAddress == swc_pkg::OFF_CTRL) begin
                next_cur.rdata = {31'h0000_0000, cur.wdtEn};
                if (avsWrite && avsByteEnable[0]) begin
                    next_cur.wdtEn = avsWriteData[swc_pkg::WDTEN_BIT];
                end
            end else begin
                next_cur.resp = 2'h2; // Unmapped: slave error
            end
        end
        // interrupt pin flag sets in Q4-Q1; set beats a bus clear
        if (irqEdge && phaseQ4Q1) begin
            next_cur.intCtl[swc_pkg::EXT_IRQ_FLAG_BIT] = 1'b1;
        end
        if ((pinChange & cur.chgEn[5:0]) != 6'h00) begin
            next_cur.intCtl[swc_pkg::CHGF_BIT] = 1'b1;
        end
        // only listed sources flag in sleep
        if (cur.state == swc_pkg::SWC_SLEEP) begin
            next_cur.pFlags = next_cur.pFlags | (periphEvent & swc_pkg::PFLAG_SLEEPOK);
        end else begin
            next_cur.pFlags = next_cur.pFlags | (periphEvent & swc_pkg::PFLAG_MASK);
        end
        if (watchdogClearInstr) begin
            next_cur.wdClr = 1'b1;
        end
        case (cur.state)
            swc_pkg::SWC_RUN: begin
                if (sleepInstr) begin
                    next_cur.pref = 1'b1;
                    if (!intPending) begin
                        next_cur.wdClr = 1'b1;
                        next_cur.powerdownFlagN = 1'b0;
                        next_cur.timeoutFlagN = 1'b1;
                        next_cur.pinHold = pinOut;
                        next_cur.oeHold = pinOutEnableN;
                        next_cur.state = swc_pkg::SWC_SLEEP;
                    end
                end
            end
            swc_pkg::SWC_SLEEP: begin
                // wake sources; wakes at once if already pending
                if (mclrLow) begin
                    next_cur.coreRst = 1'b1;
                    next_cur.wdClr = 1'b1;
                    next_cur.state = swc_pkg::SWC_RUN;
                end else if (cur.wdtEn && watchdogTimeout) begin
                    next_cur.timeoutFlagN = 1'b0;
                    next_cur.wdClr = 1'b1;
                    next_cur.vecPend = 1'b0;
                    next_cur.latCnt = 3'(LATENCY - 1);
                    next_cur.state = swc_pkg::SWC_WAKE;
                end else if (wakeRequest) begin
                    // individual enable only; vector if global enable
                    next_cur.wdClr = 1'b1;
                    next_cur.vecPend = cur.intCtl[swc_pkg::GIE_BIT];
                    next_cur.latCnt = 3'(LATENCY - 1);
                    next_cur.state = swc_pkg::SWC_WAKE;
                end
            end
            swc_pkg::SWC_WAKE: begin
                // Vector choice was frozen at wake; later enable writes cannot alter it
                // fixed wake latency
                if (cur.latCnt == 3'h0) begin
                    next_cur.vec = cur.vecPend;
                    next_cur.state = swc_pkg::SWC_RUN;
                end else begin
                    next_cur.latCnt = cur.latCnt - 3'h1;
                end
            end
            default: begin
                next_cur.state = swc_pkg::SWC_RUN;
            end
        endcase
    end

    // State register; power-down flag set by power-on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.state <= swc_pkg::SWC_RUN;
            cur.intCtl <= swc_pkg::RST_INTCTL;
            cur.chgEn <= swc_pkg::RST_CHGEN;
            cur.pFlags <= swc_pkg::RST_PFLAGS;
            cur.pEn <= swc_pkg::RST_PEN;
            cur.powerdownFlagN <= 1'b1;
            cur.timeoutFlagN <= 1'b1;
            // Preset to idle high so release never looks like a pin reset
            cur.mclrSync <= 2'h3;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign sleeping = cur.state == swc_pkg::SWC_SLEEP;
    assign oscDriverEnable = !sleeping;
    assign heldPinOut = sleeping ? cur.pinHold : pinOut;
    assign heldPinOutEnableN = sleeping ? cur.oeHold : pinOutEnableN;
    assign watchdogClear = cur.wdClr;
    assign coreReset = cur.coreRst;
    assign externalResetDriveN = 1'b1;
    assign prefetchNext = cur.pref;
    assign wakeVector = cur.vec;
    assign vectorAddress = swc_pkg::IRQ_VECTOR;
    assign avsReadData = cur.rdata;
    assign avsResponse = cur.resp;
    assign avsWaitRequest = (avsRead | avsWrite) & ~cur.ack;

    // Cycles from the wake decision to running again; follows the parameter
    localparam int LAT_CHK = LATENCY;

    // Checks, sampled on clk and idle while reset is held
    // entry needs instruction
    a_sleep_needs_instr: assert property (@(posedge clk) disable iff (rst)
        $rose(sleeping) |-> $past(sleepInstr)) else $error("sleep without instruction");
    a_sleep_flags: assert property (@(posedge clk) disable iff (rst)
        $rose(sleeping) |-> !cur.powerdownFlagN && cur.timeoutFlagN && watchdogClear)
        else $error("sleep flags wrong");
    a_osc_off: assert property (@(posedge clk) disable iff (rst)
        sleeping |-> !oscDriverEnable) else $error("oscillator running in sleep");
    a_pins_held: assert property (@(posedge clk) disable iff (rst)
        sleeping && $past(sleeping) |-> $stable(heldPinOut) && $stable(heldPinOutEnableN))
        else $error("pins changed in sleep");
    a_no_pin_drive: assert property (@(posedge clk) disable iff (rst)
        watchdogTimeout |-> externalResetDriveN) else $error("reset pin driven");
    // no-op sleep; a software clear strobe is a legal clear
    a_pending_nop: assert property (@(posedge clk) disable iff (rst)
        sleepInstr && intPending && cur.state == swc_pkg::SWC_RUN && !watchdogClearInstr
        |=> !sleeping && $stable(cur.powerdownFlagN) && $stable(cur.timeoutFlagN)
        && !watchdogClear) else $error("sleep not a no-op");
    a_wake_latency: assert property (@(posedge clk) disable iff (rst)
        sleeping && wakeRequest && !mclrLow && !(cur.wdtEn && watchdogTimeout)
        |=> ##LAT_CHK cur.state == swc_pkg::SWC_RUN) else $error("wake latency wrong");
    a_wake_clears_wdt: assert property (@(posedge clk) disable iff (rst)
        sleeping && !next_cur.state[0] |=> watchdogClear) else $error("wake kept count");
    a_external_reset_pin_reset: assert property (@(posedge clk) disable iff (rst)
        sleeping && mclrLow |=> coreReset && !sleeping) else $error("no reset on pin wake");
    a_prefetch_pulse: assert property (@(posedge clk) disable iff (rst)
        sleepInstr && cur.state == swc_pkg::SWC_RUN |=> prefetchNext)
        else $error("no prefetch after sleep instruction");
    a_wdt_wake_flag: assert property (@(posedge clk) disable iff (rst)
        sleeping && !mclrLow && cur.wdtEn && watchdogTimeout
        |=> !cur.timeoutFlagN && !coreReset) else $error("watchdog wake wrong");
    a_vector_with_gie: assert property (@(posedge clk) disable iff (rst)
        sleeping && wakeRequest && !mclrLow && !(cur.wdtEn && watchdogTimeout)
        && cur.intCtl[swc_pkg::GIE_BIT]
        |=> ##LAT_CHK wakeVector) else $error("no vector after wake");
    a_resume_in_line: assert property (@(posedge clk) disable iff (rst)
        sleeping && wakeRequest && !mclrLow && !(cur.wdtEn && watchdogTimeout)
        && !cur.intCtl[swc_pkg::GIE_BIT]
        |=> ##LAT_CHK !wakeVector && !coreReset) else $error("vector without global enable");
    a_clocked_quiet: assert property (@(posedge clk) disable iff (rst)
        sleeping && !(busReq && avsWrite)
        |=> (cur.pFlags & ~$past(cur.pFlags) & ~swc_pkg::PFLAG_SLEEPOK) == 8'h00)
        else $error("clocked peripheral flagged in sleep");
    a_wake_enabled: assert property (@(posedge clk) disable iff (rst)
        sleeping && !mclrLow && !(cur.wdtEn && watchdogTimeout) && !wakeRequest
        |=> sleeping) else $error("wake without enabled source");
    a_irq_phase: assert property (@(posedge clk) disable iff (rst)
        !phaseQ4Q1 && !(busReq && avsWrite && avsAddress == swc_pkg::OFF_INTCTL)
        |=> $stable(cur.intCtl[swc_pkg::EXT_IRQ_FLAG_BIT])) else $error("interrupt flag off phase");

    // Main scenarios
    c_int_wake: cover property (@(posedge clk) disable iff (rst)
        $fell(sleeping) ##LAT_CHK wakeVector);
    c_wdt_wake: cover property (@(posedge clk) disable iff (rst)
        sleeping && cur.wdtEn && watchdogTimeout);
    c_nop_sleep: cover property (@(posedge clk) disable iff (rst) sleepInstr && intPending);
    c_pin_wake: cover property (@(posedge clk) disable iff (rst) sleeping && mclrLow);
    c_off_phase: cover property (@(posedge clk) disable iff (rst) irqEdge && !phaseQ4Q1);
endmodule

// [test/sleep_wakeup_control_bench.sv]
// Self-checking bench for the sleep and wake-up controller.
// Assumes the core model on the far side; bus waits on waitrequest, wakes within a few cycles.
`timescale 1ns/1ps
module sleep_wakeup_control_bench;
    logic clk = 0, rst = 1, avsRead = 0, avsWrite = 0, sleepReq = 0, pinReset = 0, phase = 1;
    logic wdTo = 0, extIrqPin = 0, sleepInstr, extRst, avsWaitRequest, sleeping;
    logic [7:0] avsAddress = 0, periphEvent = 0, clrCount, vectorAddress;
    logic [31:0] avsWriteData = 0, avsReadData, q;
    logic [1:0] avsResponse, r;
    logic [5:0] pinChange = 0, pinOut, pinOe, hOut, hOe, h0, e0;
    logic oscDriverEnable, watchdogClear, coreReset, extDrvN, prefetchNext, wakeVector;
    logic [7:0] pfCnt = 0, wvCnt = 0, crCnt = 0, c0;
    int err_count = 0, n_checks = 0;
    swc_sleep_wakeup_control dut (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .avsResponse(avsResponse), .sleepInstr(sleepInstr), .watchdogClearInstr(1'b0),
        .watchdogTimeout(wdTo), .externalResetPin(extRst), .extIrqPin(extIrqPin),
        .phaseQ4Q1(phase), .pinChange(pinChange), .periphEvent(periphEvent),
        .pinOut(pinOut), .pinOutEnableN(pinOe), .heldPinOut(hOut),
        .heldPinOutEnableN(hOe), .oscDriverEnable(oscDriverEnable),
        .watchdogClear(watchdogClear), .coreReset(coreReset),
        .externalResetDriveN(extDrvN), .prefetchNext(prefetchNext),
        .wakeVector(wakeVector), .vectorAddress(vectorAddress), .sleeping(sleeping));
    swc_core_model core (.clk(clk), .rst(rst), .sleepReq(sleepReq), .pinReset(pinReset),
        .watchdogClear(watchdogClear), .sleepInstr(sleepInstr), .externalResetPin(extRst),
        .pinOut(pinOut), .pinOutEnableN(pinOe), .clrCount(clrCount));
    // Clock, 8 ns period
    initial begin
        forever #4 clk = ~clk;
    end
    // Pulse counters on design strobes
    always @(posedge clk) begin
        pfCnt <= pfCnt + {7'h00, prefetchNext};
        wvCnt <= wvCnt + {7'h00, wakeVector};
        crCnt <= crCnt + {7'h00, coreReset};
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        do begin
            @(posedge clk);
        end while (avsWaitRequest !== 1'b0);
        q = avsReadData;
        r = avsResponse;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e, "read data");
    endtask
    // Wait a bounded time for the sleep state to reach v
    task ws(input logic v);
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            if (sleeping === v) break;
        end
        chk(sleeping, v, "sleeping");
    endtask
    task go_sleep;
        @(posedge clk) sleepReq <= 1'b1;
        @(posedge clk) sleepReq <= 1'b0;
    endtask
    task t_reset;
        rd(swc_pkg::OFF_INTCTL, 32'h0);
        rd(swc_pkg::OFF_PFLAGS, 32'h0);
        rd(swc_pkg::OFF_PEN, 32'h0);
        rd(swc_pkg::OFF_STATUS, 32'h3);
        bus(1'b1, swc_pkg::OFF_CHGEN, 32'h3F);
        rd(swc_pkg::OFF_CHGEN, 32'h3F);
        rd(8'h40, 32'h0);
        chk(r, 2'b10, "unmapped response");
        chk(sleeping, 1'b0, "no sleep");
    endtask
    task t_nop;
        c0 = clrCount;
        bus(1'b1, swc_pkg::OFF_INTCTL, 32'h09);
        go_sleep;
        repeat (6) @(negedge clk);
        chk(sleeping, 1'b0, "nop sleep");
        chk(clrCount, c0, "watchdog kept");
        rd(swc_pkg::OFF_STATUS, 32'h3);
    endtask
    task t_pin;
        bus(1'b1, swc_pkg::OFF_PEN, 32'h02);
        bus(1'b1, swc_pkg::OFF_INTCTL, 32'h48);
        c0 = clrCount;
        go_sleep;
        ws(1'b1);
        chk(oscDriverEnable, 1'b0, "osc driver");
        h0 = hOut;
        e0 = hOe;
        @(posedge clk) periphEvent <= 8'h02;
        @(posedge clk) periphEvent <= 8'h00;
        repeat (8) @(negedge clk);
        chk(sleeping, 1'b1, "clocked periph");
        chk(pfCnt, 8'h2, "prefetch, no-op sleep included");
        chk({hOut, hOe}, {h0, e0}, "held pins");
        @(posedge clk) pinChange <= 6'h04;
        @(posedge clk) pinChange <= 6'h00;
        ws(1'b0);
        repeat (6) @(negedge clk);
        chk(clrCount, c0 + 8'h2, "watchdog clears");
        chk(wvCnt, 8'h0, "no vector");
        rd(swc_pkg::OFF_STATUS, 32'h2);
        bus(1'b1, swc_pkg::OFF_PFLAGS, 32'h0);
        bus(1'b1, swc_pkg::OFF_PEN, 32'h0);
    endtask
    task t_gie;
        bus(1'b1, swc_pkg::OFF_INTCTL, 32'h90);
        go_sleep;
        ws(1'b1);
        // Edge outside the phase window is dropped, so no wake
        @(posedge clk);
        phase <= 1'b0;
        extIrqPin <= 1'b1;
        repeat (6) @(negedge clk);
        chk(sleeping, 1'b1, "off-phase edge");
        @(posedge clk);
        phase <= 1'b1;
        extIrqPin <= 1'b0;
        repeat (4) @(posedge clk);
        extIrqPin <= 1'b1;
        ws(1'b0);
        repeat (8) @(negedge clk);
        chk(wvCnt, 8'h1, "vector pulse");
        chk(vectorAddress, swc_pkg::IRQ_VECTOR, "vector");
        @(posedge clk) extIrqPin <= 1'b0;
        bus(1'b1, swc_pkg::OFF_INTCTL, 32'h0);
    endtask
    task t_wdt;
        bus(1'b1, swc_pkg::OFF_CTRL, 32'h1);
        c0 = clrCount;
        go_sleep;
        ws(1'b1);
        @(negedge clk);
        chk(clrCount, c0 + 8'h1, "entry clear");
        @(posedge clk) wdTo <= 1'b1;
        @(posedge clk) wdTo <= 1'b0;
        ws(1'b0);
        chk(extDrvN, 1'b1, "reset pin drive");
        chk(crCnt, 8'h0, "no core reset");
        rd(swc_pkg::OFF_STATUS, 32'h0);
        bus(1'b1, swc_pkg::OFF_CTRL, 32'h0);
    endtask
    task t_rpin;
        go_sleep;
        ws(1'b1);
        @(posedge clk) pinReset <= 1'b1;
        repeat (6) @(posedge clk);
        pinReset <= 1'b0;
        repeat (4) @(negedge clk);
        chk(crCnt, 8'h1, "core reset");
        chk(sleeping, 1'b0, "awake after pin reset");
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Whole run is well under 2000 cycles
    initial begin
        #100000;
        err_count++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_nop;
        t_pin;
        t_gie;
        t_wdt;
        t_rpin;
        complete_run;
    end
endmodule

// [test/swc_core_model.sv]
// Core-side partner: sleep strobe, reset pin, toggling pin drive, watchdog clear count.
// Assumes one clock; bench asks for sleep and pin reset through request inputs.
`timescale 1ns/1ps
module swc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic sleepReq,
    input wire logic pinReset,
    input wire logic watchdogClear,
    output logic sleepInstr,
    output logic externalResetPin,
    output logic [5:0] pinOut,
    output logic [5:0] pinOutEnableN,
    output logic [7:0] clrCount
);
    // Strobes follow requests by one cycle; drive state toggles every cycle
    // so a held copy cannot pass by accident
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleepInstr <= 1'b0;
            externalResetPin <= 1'b1;
            pinOut <= 6'h15;
            pinOutEnableN <= 6'h0C;
            clrCount <= 8'h00;
        end else begin
            sleepInstr <= sleepReq;
            externalResetPin <= !pinReset;
            pinOut <= ~pinOut;
            pinOutEnableN <= ~pinOutEnableN;
            clrCount <= clrCount + {7'h00, watchdogClear};
        end
    end
endmodule
